// *** design/flag_bank_pkg.sv ***
// shared offsets, field positions and reset values of the flag bank
package flag_bank_pkg;
  // word indexes; the bus byte address is four times the index
  localparam logic [11:0] IDX_PORT_ENABLED = 12'h0ca;
  localparam logic [11:0] IDX_RESP_CODE0 = 12'h0cb;
  localparam logic [11:0] IDX_PORT_EXEC_ERR = 12'h0db;
  localparam logic [11:0] IDX_UNIT_INIT = 12'h12e;
  localparam logic [11:0] IDX_FATAL = 12'h191;
  localparam logic [11:0] IDX_UNIT_ERR_SUM = 12'h192;
  localparam logic [11:0] IDX_DUP_UNIT = 12'h19a;
  localparam logic [11:0] IDX_UNIT_ERR_NUM = 12'h1a1;
  localparam logic [11:0] IDX_UNIT_ERR_NUM2 = 12'h1a6;
  localparam logic [11:0] IDX_SET_ERR_UNIT = 12'h1ab;
  localparam logic [11:0] IDX_RESTART = 12'h1f5;
  localparam logic [11:0] IDX_REG_TABLE = 12'h200;
  localparam logic [11:0] IDX_IRQ_STATUS = 12'h201;
  localparam logic [11:0] IDX_IRQ_MASK = 12'h202;
  localparam logic [11:0] IDX_AREA_BASE = 12'h5dc;
  localparam logic [11:0] AREA_WORDS_PER_UNIT = 12'h019;
  localparam logic [11:0] AREA_WORDS = 12'h190;
  // offsets inside one unit block
  localparam logic [4:0] OFS_ERROR_DATA = 5'h01;
  localparam logic [4:0] OFS_NET_FIRST = 5'h02;
  localparam logic [4:0] OFS_NET_LAST = 5'h07;
  localparam logic [4:0] OFS_LINK_FIRST = 5'h08;
  localparam logic [4:0] OFS_LINK_LAST = 5'h17;
  localparam logic [4:0] OFS_POWER = 5'h18;
  localparam int LINK_ACTIVE_BIT = 15;
  // field positions in the flag words
  localparam int FATAL_DUP_BIT = 13;
  localparam int SUM_SETTING_BIT = 3;
  localparam int SUM_UNIT_ERR_BIT = 7;
  // interrupt status bits
  localparam int IRQ_EXEC_ERR = 0;
  localparam int IRQ_SETTING = 1;
  localparam int IRQ_PARITY = 2;
  localparam int IRQ_DUP = 3;
  localparam int IRQ_UNIT_ERR = 4;
  localparam int IRQ_RESTART_DONE = 5;
  localparam int IRQ_BITS = 6;
  // reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [5:0] RST_IRQ = 6'h00;
endpackage

// *** design/unit_status_area.sv ***
// per-unit 25-word status area with write filtering for network and link status
`timescale 1ns/10ps
module unit_status_area
  import flag_bank_pkg::*;
#(
  parameter int UNITS = 16
)
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_wr,
  input wire logic [3:0] i_wr_unit,
  input wire logic [4:0] i_wr_ofs,
  input wire logic [15:0] i_wr_data,
  input wire logic [UNITS-1:0] i_online,
  input wire logic [6:0] i_local_node,
  input wire logic [8:0] i_rd_word,
  output logic [15:0] o_rd_data
);
  logic [15:0] mem_q [0:UNITS*AREA_WORDS_PER_UNIT-1];
  logic [UNITS-1:0] online_q;
  logic [8:0] wr_word;
  logic [8:0] base_word;
  logic wr_ok;
  logic drop_q;
  logic [3:0] drop_unit_q;
  logic [8:0] clr_word;
  logic [15:0] clr_mask;

  // block base of a unit: 25 words per unit
  function automatic logic [8:0] unit_base(input logic [3:0] unit);
    unit_base = 9'(unit) * 9'(AREA_WORDS_PER_UNIT);
  endfunction

  assign base_word = unit_base(i_wr_unit);
  assign wr_word = base_word + 9'(i_wr_ofs);

  // filter: offline units keep other nodes frozen, an idle link keeps its status
  always_comb
  begin
    wr_ok = i_wr && (i_wr_ofs <= OFS_POWER);
    if ((i_wr_ofs >= OFS_NET_FIRST) && (i_wr_ofs <= OFS_NET_LAST) && !i_online[i_wr_unit])
      wr_ok = 1'b0;
    if ((i_wr_ofs >= OFS_LINK_FIRST) && (i_wr_ofs < OFS_LINK_LAST) &&
        !mem_q[base_word + 9'(OFS_LINK_LAST)][LINK_ACTIVE_BIT])
      wr_ok = 1'b0;
  end

  // the local node's bit: 16 bits per network word starting at offset 2
  assign clr_word = unit_base(drop_unit_q) + 9'(OFS_NET_FIRST) + 9'(i_local_node[6:4]);
  assign clr_mask = 16'h0001 << i_local_node[3:0];

  // falling online level of a unit; of several units falling in one cycle only the lowest is served
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      online_q <= '0;
      drop_q <= 1'b0;
      drop_unit_q <= 4'h0;
    end
    else
    begin
      online_q <= i_online;
      drop_q <= 1'b0;
      for (int u = UNITS - 1; u >= 0; u--)
        if (online_q[u] && !i_online[u])
        begin
          drop_q <= 1'b1;
          drop_unit_q <= 4'(u);
        end
    end
  end

  // storage; a local-node clear wins over a unit write in the same cycle
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      for (int w = 0; w < UNITS * int'(AREA_WORDS_PER_UNIT); w++)
        mem_q[w] <= RST_WORD;
    end
    else if (drop_q)
      mem_q[clr_word] <= mem_q[clr_word] & ~clr_mask;
    else if (wr_ok)
      mem_q[wr_word] <= i_wr_data;
  end

  assign o_rd_data = (i_rd_word < 9'(UNITS * AREA_WORDS_PER_UNIT)) ?
                     mem_q[i_rd_word] : RST_WORD;
endmodule

// *** design/flag_bank.sv ***
// bus unit status and control flag bank behind a classic wishbone slave
// Contract
// - port enabled bit follows each port's ability to run network instructions
// - port execute error bit set when a port's transfer ends in error
// - each port's response code lands in its own consecutive 16-bit word
// - unit initializing bit high exactly while that unit initializes
// - setting error flag set when installed units differ from registered table
// - setting error word marks each mismatching unit number
// - parity error sets unit error flag and that unit's bit
// - duplicate word marks each unit number used twice
// - duplicate number fatal flag set whenever two units share a number
// - second unit error word marks the unit of each unit error
// - software sets restart bit, device clears it when restart completes
// - 25-word status block per unit at word 1500 plus 25 times unit
// - block holds error data, network, data link and power status
// - offline local node clears only its own bit, others stay frozen; only the lowest of units dropping in one cycle is cleared
// - data link status frozen while local link active bit is clear
`timescale 1ns/10ps
module flag_bank
  import flag_bank_pkg::*;
#(
  parameter int PORTS = 8,
  parameter int UNITS = 16
)
(
  input wire logic I_REF_CLK,
  input wire logic I_SRST,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [13:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  input wire logic [PORTS-1:0] I_PORT_ENABLED,
  input wire logic I_PORT_DONE,
  input wire logic [2:0] I_PORT_NUM,
  input wire logic [15:0] I_PORT_CODE,
  input wire logic I_PORT_ERR,
  input wire logic [UNITS-1:0] I_UNIT_INIT,
  input wire logic [UNITS-1:0] I_UNIT_INSTALLED,
  input wire logic [UNITS-1:0] I_UNIT_DUP,
  input wire logic I_PARITY_ERR,
  input wire logic [3:0] I_PARITY_UNIT,
  input wire logic I_UNIT_ERR,
  input wire logic [3:0] I_UNIT_ERR_NUM,
  input wire logic [UNITS-1:0] I_RESTART_DONE,
  input wire logic I_STAT_WR,
  input wire logic [3:0] I_STAT_UNIT,
  input wire logic [4:0] I_STAT_OFS,
  input wire logic [15:0] I_STAT_DATA,
  input wire logic [UNITS-1:0] I_LOCAL_ONLINE,
  input wire logic [6:0] I_LOCAL_NODE,
  output logic [UNITS-1:0] O_UNIT_RESTART,
  output logic O_IRQ
);
  logic [11:0] idx;
  logic bus_req;
  logic wr_take;
  logic [15:0] wr_val;
  logic [15:0] rd_word;
  logic [15:0] area_rd;
  logic [8:0] area_word;
  logic [PORTS-1:0] port_en_q;
  logic [PORTS-1:0] exec_err_q;
  logic [15:0] resp_q [0:PORTS-1];
  logic [UNITS-1:0] init_q;
  logic [UNITS-1:0] reg_table_q;
  logic [UNITS-1:0] set_err_q;
  logic [UNITS-1:0] dup_q;
  logic [UNITS-1:0] parity_units_q;
  logic [UNITS-1:0] unit_err_q;
  logic parity_flag_q;
  logic [UNITS-1:0] restart_q;
  logic [UNITS-1:0] restart_d;
  logic [IRQ_BITS-1:0] irq_stat_q;
  logic [IRQ_BITS-1:0] irq_mask_q;
  logic [IRQ_BITS-1:0] irq_ev;

  // one-hot decode of a unit number, used by several flag words
  function automatic logic [UNITS-1:0] unit_bit(input logic [3:0] unit);
    unit_bit = '0;
    unit_bit[unit] = 1'b1;
  endfunction

  // bus decode: printed offsets are word indexes, byte address is four times them
  assign idx = I_WB_ADR[13:2];
  assign bus_req = I_WB_CYC && I_WB_STB;
  // write acts at the edge where the master sees ack
  assign wr_take = bus_req && I_WB_WE && O_WB_ACK;
  assign wr_val = {I_WB_SEL[1] ? I_WB_DAT[15:8] : 8'h00, I_WB_SEL[0] ? I_WB_DAT[7:0] : 8'h00};
  assign area_word = 9'(idx - IDX_AREA_BASE);

  unit_status_area #(
    .UNITS(UNITS)
  ) u_area (
    .i_clk(I_REF_CLK),
    .i_srst(I_SRST),
    .i_wr(I_STAT_WR),
    .i_wr_unit(I_STAT_UNIT),
    .i_wr_ofs(I_STAT_OFS),
    .i_wr_data(I_STAT_DATA),
    .i_online(I_LOCAL_ONLINE),
    .i_local_node(I_LOCAL_NODE),
    .i_rd_word(area_word),
    .o_rd_data(area_rd)
  );

  // read mux; unmapped words and unused upper bits read zero
  always_comb
  begin
    rd_word = 16'h0000;
    if (idx >= IDX_RESP_CODE0 && idx < IDX_RESP_CODE0 + 12'(PORTS))
      rd_word = resp_q[3'(idx - IDX_RESP_CODE0)];
    else if (idx >= IDX_AREA_BASE && idx < IDX_AREA_BASE + AREA_WORDS)
      rd_word = area_rd;
    else
      case (idx)
        IDX_PORT_ENABLED: rd_word = 16'(port_en_q);
        IDX_PORT_EXEC_ERR: rd_word = 16'(exec_err_q);
        IDX_UNIT_INIT: rd_word = 16'(init_q);
        IDX_FATAL: rd_word[FATAL_DUP_BIT] = |dup_q;
        IDX_UNIT_ERR_SUM:
        begin
          rd_word[SUM_SETTING_BIT] = |set_err_q;
          rd_word[SUM_UNIT_ERR_BIT] = parity_flag_q;
        end
        IDX_DUP_UNIT: rd_word = 16'(dup_q);
        IDX_UNIT_ERR_NUM: rd_word = 16'(parity_units_q);
        IDX_UNIT_ERR_NUM2: rd_word = 16'(unit_err_q);
        IDX_SET_ERR_UNIT: rd_word = 16'(set_err_q);
        IDX_RESTART: rd_word = 16'(restart_q);
        IDX_REG_TABLE: rd_word = 16'(reg_table_q);
        IDX_IRQ_STATUS: rd_word = 16'(irq_stat_q);
        IDX_IRQ_MASK: rd_word = 16'(irq_mask_q);
        default: rd_word = 16'h0000;
      endcase
  end

  // wishbone answer: ack one cycle after the request, dropped the cycle after
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_SRST)
    begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h0000_0000;
    end
    else
    begin
      O_WB_ACK <= bus_req && !O_WB_ACK;
      if (bus_req && !O_WB_ACK)
        O_WB_DAT <= {16'h0000, rd_word};
    end
  end

  // port flags follow the hardware; error flag tracks the last transfer result
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_SRST)
    begin
      port_en_q <= '0;
      exec_err_q <= '0;
      for (int p = 0; p < PORTS; p++)
        resp_q[p] <= RST_WORD;
    end
    else
    begin
      port_en_q <= I_PORT_ENABLED;
      if (I_PORT_DONE)
      begin
        exec_err_q[I_PORT_NUM] <= I_PORT_ERR;
        resp_q[I_PORT_NUM] <= I_PORT_CODE;
      end
    end
  end

  // unit level flags mirror the unit presence, init and numbering state
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_SRST)
    begin
      init_q <= '0;
      set_err_q <= '0;
      dup_q <= '0;
    end
    else
    begin
      init_q <= I_UNIT_INIT;
      set_err_q <= I_UNIT_INSTALLED ^ reg_table_q;
      dup_q <= I_UNIT_DUP;
    end
  end

  // error words are sticky; only reset clears them since software cannot write
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_SRST)
    begin
      parity_flag_q <= 1'b0;
      parity_units_q <= '0;
      unit_err_q <= '0;
    end
    else
    begin
      if (I_PARITY_ERR)
      begin
        parity_flag_q <= 1'b1;
        parity_units_q <= parity_units_q | unit_bit(I_PARITY_UNIT);
      end
      if (I_UNIT_ERR)
        unit_err_q <= unit_err_q | unit_bit(I_UNIT_ERR_NUM);
    end
  end

  // restart bits: software sets, completion clears and wins over a new set
  always_comb
  begin
    restart_d = restart_q;
    if (wr_take && idx == IDX_RESTART)
      restart_d = restart_d | wr_val[UNITS-1:0];
    restart_d = restart_d & ~I_RESTART_DONE;
  end

  // software-owned words; every other word except the interrupt status ignores writes
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_SRST)
    begin
      restart_q <= '0;
      reg_table_q <= '0;
      irq_mask_q <= RST_IRQ;
    end
    else
    begin
      restart_q <= restart_d;
      if (wr_take && idx == IDX_REG_TABLE)
        reg_table_q <= wr_val[UNITS-1:0];
      if (wr_take && idx == IDX_IRQ_MASK)
        irq_mask_q <= wr_val[IRQ_BITS-1:0];
    end
  end

  assign O_UNIT_RESTART = restart_q;

  // interrupt events
  always_comb
  begin
    irq_ev = '0;
    irq_ev[IRQ_EXEC_ERR] = I_PORT_DONE && I_PORT_ERR;
    irq_ev[IRQ_SETTING] = |(I_UNIT_INSTALLED ^ reg_table_q);
    irq_ev[IRQ_PARITY] = I_PARITY_ERR;
    irq_ev[IRQ_DUP] = |I_UNIT_DUP;
    irq_ev[IRQ_UNIT_ERR] = I_UNIT_ERR;
    irq_ev[IRQ_RESTART_DONE] = |(restart_q & I_RESTART_DONE);
  end

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_SRST)
    begin
      irq_stat_q <= RST_IRQ;
      O_IRQ <= 1'b0;
    end
    else
    begin
      if (wr_take && idx == IDX_IRQ_STATUS)
        irq_stat_q <= (irq_stat_q & ~wr_val[IRQ_BITS-1:0]) | irq_ev;
      else
        irq_stat_q <= irq_stat_q | irq_ev;
      O_IRQ <= |(irq_stat_q & irq_mask_q);
    end
  end

  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_SRST);

  // bus handshake: one ack per request, none while idle
  AST_ACK: assert property (bus_req && !O_WB_ACK |=> O_WB_ACK ##1 !O_WB_ACK)
    else $error("ack timing wrong");
  AST_ACK_IDLE: assert property (!bus_req |=> !O_WB_ACK)
    else $error("ack without a request");
  AST_WB_UPPER: assert property (O_WB_ACK |-> O_WB_DAT[31:16] == 16'h0000)
    else $error("upper read data not zero");

  // port flags and response words
  AST_PORT_EN: assert property (##1 port_en_q == $past(I_PORT_ENABLED))
    else $error("port enabled flags do not follow the ports");
  AST_EXEC_ERR: assert property (I_PORT_DONE && I_PORT_ERR |=> exec_err_q[$past(I_PORT_NUM)])
    else $error("execute error not flagged");
  AST_EXEC_OK: assert property (I_PORT_DONE && !I_PORT_ERR |=>
    !exec_err_q[$past(I_PORT_NUM)])
    else $error("execute error kept after a clean transfer");
  AST_RESP: assert property (I_PORT_DONE |=> resp_q[$past(I_PORT_NUM)] == $past(I_PORT_CODE))
    else $error("response code not stored");

  // unit flags; sticky words must record each reported unit
  AST_INIT: assert property (##1 init_q == $past(I_UNIT_INIT))
    else $error("initializing flags wrong");
  AST_SETTING: assert property (I_UNIT_INSTALLED != reg_table_q |=> |set_err_q)
    else $error("setting mismatch not flagged");
  AST_SUM: assert property (bus_req && !O_WB_ACK && |set_err_q &&
    idx == IDX_UNIT_ERR_SUM |=> O_WB_DAT[SUM_SETTING_BIT])
    else $error("setting error flag not read back");
  AST_SET_UNITS: assert property (##1 set_err_q == $past(I_UNIT_INSTALLED ^ reg_table_q))
    else $error("setting error unit bits wrong");
  AST_PARITY: assert property (I_PARITY_ERR |=>
    parity_flag_q && parity_units_q[$past(I_PARITY_UNIT)])
    else $error("parity error not recorded");
  AST_DUP: assert property (|I_UNIT_DUP |=> dup_q == $past(I_UNIT_DUP) && |dup_q)
    else $error("duplicate unit bits wrong");
  AST_FATAL: assert property (bus_req && !O_WB_ACK && |dup_q &&
    idx == IDX_FATAL |=> O_WB_DAT[FATAL_DUP_BIT])
    else $error("fatal duplicate flag missing");
  AST_UNIT_ERR: assert property (I_UNIT_ERR |=> unit_err_q[$past(I_UNIT_ERR_NUM)])
    else $error("unit error bit not set");
  AST_RO: assert property (wr_take && idx == IDX_SET_ERR_UNIT |=>
    set_err_q == $past(I_UNIT_INSTALLED ^ reg_table_q))
    else $error("read-only word changed by a write");

  // restart bits; completion beats a same-cycle software set
  AST_RESTART: assert property (##1 (O_UNIT_RESTART & $past(I_RESTART_DONE)) == '0)
    else $error("restart bit not cleared on completion");
  AST_RESTART_SET: assert property (wr_take && idx == IDX_RESTART |=>
    ((restart_q | $past(I_RESTART_DONE)) & $past(wr_val[UNITS-1:0])) == $past(wr_val[UNITS-1:0]))
    else $error("restart bit not set by software");

  // interrupt; a late clear must never swallow a fresh event
  AST_IRQ: assert property (|(irq_stat_q & irq_mask_q) |=> O_IRQ)
    else $error("interrupt not raised");
  AST_IRQ_LOW: assert property ((irq_stat_q & irq_mask_q) == '0 |=> !O_IRQ)
    else $error("interrupt raised with nothing pending");
  AST_IRQ_SET_WINS: assert property (##1 (irq_stat_q & $past(irq_ev)) == $past(irq_ev))
    else $error("status event lost");

  // main scenarios
  COV_WRITE: cover property (wr_take && idx == IDX_RESTART);
  COV_DONE: cover property (I_PORT_DONE ##1 bus_req && idx == IDX_RESP_CODE0);
  COV_PARITY_IRQ: cover property (I_PARITY_ERR ##[1:3] O_IRQ);
  COV_RESTART: cover property (restart_q[0] ##[1:20] !restart_q[0]);
  COV_IRQ_CLEAR: cover property (wr_take && idx == IDX_IRQ_STATUS ##2 !O_IRQ);
endmodule

// *** tb/unit_responder.sv ***
// bus unit responder model: finishes restarts after a per-unit delay
`timescale 1ns/10ps
module unit_responder
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [15:0] i_restart,
  output logic [15:0] o_done,
  output logic [15:0] o_init
);
  logic [4:0] cnt_q [16];
  // a unit reports initializing for the whole of its restart
  assign o_init = i_restart;
  // unit u needs u+3 cycles, so low units answer fast and high ones slow
  always_ff @(posedge i_clk)
  begin
    for (int u = 0; u < 16; u++)
    begin
      o_done[u] <= 1'b0;
      if (i_srst)
        cnt_q[u] <= 5'h00;
      else if (i_restart[u] && !o_done[u])
      begin
        if (cnt_q[u] == 5'(u + 2))
        begin
          o_done[u] <= 1'b1;
          cnt_q[u] <= 5'h00;
        end
        else
          cnt_q[u] <= cnt_q[u] + 5'h01;
      end
    end
  end
endmodule

// *** tb/flag_bank_tb.sv ***
// flag bank testbench: bus tasks, scenarios and verdict
`timescale 1ns/10ps
module flag_bank_tb
  import flag_bank_pkg::*;
;
  logic clk, srst, cyc, stb, we, ack, pdone, perr, par, uerr, swr, irq;
  logic [13:0] adr;
  logic [3:0] sel, par_u, uerr_u, sunit;
  logic [31:0] wdat, rdat;
  logic [7:0] pen;
  logic [2:0] pnum;
  logic [15:0] pcode, inst, dup, sdata, online, restart, rdone, init, rd;
  logic [4:0] sofs;
  logic [6:0] node;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;

  flag_bank dut_u (.I_REF_CLK(clk), .I_SRST(srst), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat),
    .O_WB_ACK(ack), .I_PORT_ENABLED(pen), .I_PORT_DONE(pdone), .I_PORT_NUM(pnum),
    .I_PORT_CODE(pcode), .I_PORT_ERR(perr), .I_UNIT_INIT(init), .I_UNIT_INSTALLED(inst),
    .I_UNIT_DUP(dup), .I_PARITY_ERR(par), .I_PARITY_UNIT(par_u), .I_UNIT_ERR(uerr),
    .I_UNIT_ERR_NUM(uerr_u), .I_RESTART_DONE(rdone), .I_STAT_WR(swr), .I_STAT_UNIT(sunit),
    .I_STAT_OFS(sofs), .I_STAT_DATA(sdata), .I_LOCAL_ONLINE(online), .I_LOCAL_NODE(node),
    .O_UNIT_RESTART(restart), .O_IRQ(irq));
  unit_responder unit_u (.i_clk(clk), .i_srst(srst), .i_restart(restart), .o_done(rdone),
    .o_init(init));

  // 125 MHz reference clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // hang guard, well above the length of all scenarios
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      $display("CHECK FAILED t=%0t timeout", $time);
      end_sim;
    end
  end

  task end_sim;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one classic cycle; held until ack is sampled, then released
  task wb(input logic w, input logic [11:0] idx, input logic [15:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= 4'h3;
    wdat <= {16'h0000, d};
    // no cycle count assumed; only the hang guard ends a lost cycle
    do
      @(posedge clk);
    while (ack !== 1'b1);
    rd = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task rchk(input logic [11:0] idx, input logic [15:0] exp, input string what);
    wb(1'b0, idx, 16'h0000);
    chk(rd, exp, what);
  endtask

  task stat_wr(input logic [3:0] u, input logic [4:0] o, input logic [15:0] d);
    @(posedge clk);
    swr <= 1'b1;
    sunit <= u;
    sofs <= o;
    sdata <= d;
    @(posedge clk);
    swr <= 1'b0;
  endtask

  function automatic logic [11:0] aidx(input int u, input logic [4:0] o);
    return IDX_AREA_BASE + AREA_WORDS_PER_UNIT * 12'(u) + 12'(o);
  endfunction

  task t_bus;
    wb(1'b1, IDX_FATAL, 16'hffff);
    rchk(IDX_FATAL, 16'h0000, "fatal ro");
    wb(1'b1, 12'h300, 16'habcd);
    rchk(12'h300, 16'h0000, "unmapped");
    $display("test bus done");
  endtask

  task t_irq;
    logic a, b;
    @(posedge clk);
    par <= 1'b1;
    par_u <= 4'h5;
    uerr <= 1'b1;
    uerr_u <= 4'hc;
    @(posedge clk);
    par_u <= 4'h0;
    uerr <= 1'b0;
    @(posedge clk);
    par <= 1'b0;
    rchk(IDX_IRQ_STATUS, 16'h0014, "irq status");
    wb(1'b1, IDX_IRQ_MASK, 16'h003f);
    repeat (2) @(posedge clk);
    a = irq;
    wb(1'b1, IDX_IRQ_MASK, 16'h0000);
    repeat (2) @(posedge clk);
    b = irq;
    chk({15'h0000, a}, 16'h0001, "irq unmasked");
    chk({15'h0000, b}, 16'h0000, "irq masked");
    // unmask again so that the clear below is what drops the line
    wb(1'b1, IDX_IRQ_MASK, 16'h003f);
    wb(1'b1, IDX_IRQ_STATUS, 16'h003f);
    repeat (2) @(posedge clk);
    chk({15'h0000, irq}, 16'h0000, "irq clear");
    rchk(IDX_IRQ_STATUS, 16'h0000, "status clear");
    rchk(IDX_UNIT_ERR_NUM, 16'h0021, "parity units");
    rchk(IDX_UNIT_ERR_NUM2, 16'h1000, "unit err");
    rchk(IDX_UNIT_ERR_SUM, 16'h0080, "parity flag");
    $display("test irq done");
  endtask

  task t_port;
    @(posedge clk);
    pen <= 8'ha5;
    // back-to-back completions, odd ports fail
    for (int p = 0; p < 8; p++)
    begin
      pdone <= 1'b1;
      pnum <= 3'(p);
      pcode <= 16'h1100 + 16'(p);
      perr <= p[0];
      @(posedge clk);
    end
    pdone <= 1'b0;
    rchk(IDX_PORT_ENABLED, 16'h00a5, "port enabled");
    for (int p = 0; p < 8; p++)
      rchk(IDX_RESP_CODE0 + 12'(p), 16'h1100 + 16'(p), "resp code");
    rchk(IDX_PORT_EXEC_ERR, 16'h00aa, "exec err");
    @(posedge clk);
    pdone <= 1'b1;
    pnum <= 3'h1;
    pcode <= 16'h0000;
    perr <= 1'b0;
    @(posedge clk);
    pdone <= 1'b0;
    rchk(IDX_PORT_EXEC_ERR, 16'h00a8, "exec ok");
    rchk(IDX_RESP_CODE0 + 12'h001, 16'h0000, "resp code 1");
    $display("test port done");
  endtask

  task t_units;
    @(posedge clk);
    dup <= 16'h0300;
    inst <= 16'h00f0;
    wb(1'b1, IDX_REG_TABLE, 16'h00ff);
    rchk(IDX_DUP_UNIT, 16'h0300, "dup bits");
    rchk(IDX_FATAL, 16'h2000, "dup fatal");
    rchk(IDX_SET_ERR_UNIT, 16'h000f, "mismatch");
    rchk(IDX_UNIT_ERR_SUM, 16'h0088, "summary");
    wb(1'b1, IDX_SET_ERR_UNIT, 16'hffff);
    rchk(IDX_SET_ERR_UNIT, 16'h000f, "ro write");
    @(posedge clk);
    dup <= 16'h0000;
    inst <= 16'h00ff;
    repeat (2) @(posedge clk);
    rchk(IDX_FATAL, 16'h0000, "dup gone");
    rchk(IDX_SET_ERR_UNIT, 16'h0000, "match");
    rchk(IDX_UNIT_ERR_SUM, 16'h0080, "summary");
    $display("test units done");
  endtask

  task t_restart;
    logic [15:0] seen;
    int n;
    wb(1'b1, IDX_RESTART, 16'h8100);
    rchk(IDX_UNIT_INIT, 16'h8100, "initializing");
    rchk(IDX_RESTART, 16'h8100, "restart set");
    seen = 16'h0000;
    n = 0;
    // the fast unit finishes first, the slow one later
    while (restart !== 16'h0000 && n < 60)
    begin
      @(posedge clk);
      n++;
      if (restart === 16'h8000)
        seen = 16'h0001;
    end
    chk(seen, 16'h0001, "restart order");
    rchk(IDX_RESTART, 16'h0000, "restart clear");
    rchk(IDX_UNIT_INIT, 16'h0000, "init clear");
    $display("test restart done");
  endtask

  task t_area;
    stat_wr(4'h2, OFS_LINK_FIRST, 16'h1234);
    rchk(aidx(2, OFS_LINK_FIRST), 16'h0000, "link frozen");
    stat_wr(4'h2, OFS_LINK_LAST, 16'h8000);
    stat_wr(4'h2, OFS_LINK_FIRST, 16'h1234);
    rchk(aidx(2, OFS_LINK_FIRST), 16'h1234, "link live");
    rchk(aidx(2, OFS_LINK_LAST), 16'h8000, "link last");
    stat_wr(4'hf, OFS_POWER, 16'h0bee);
    rchk(aidx(15, OFS_POWER), 16'h0bee, "power");
    stat_wr(4'h0, OFS_ERROR_DATA, 16'h00e1);
    rchk(aidx(0, OFS_ERROR_DATA), 16'h00e1, "error data");
    stat_wr(4'h2, 5'h03, 16'h00ff);
    rchk(aidx(2, 5'h03), 16'h00ff, "net status");
    @(posedge clk);
    online <= 16'hfffb;
    repeat (4) @(posedge clk);
    rchk(aidx(2, 5'h03), 16'h00f7, "local bit off");
    stat_wr(4'h2, 5'h03, 16'hffff);
    rchk(aidx(2, 5'h03), 16'h00f7, "net frozen");
    $display("test area done");
  endtask

  initial
  begin
    srst = 1'b1;
    {cyc, stb, we, pdone, perr, par, uerr, swr} = 8'h00;
    adr = 14'h0000;
    sel = 4'h0;
    wdat = 32'h00000000;
    {par_u, uerr_u, sunit, pnum, sofs} = 20'h00000;
    {pen, pcode, inst, dup, sdata} = 72'h0;
    online = 16'hffff;
    node = 7'h13;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    t_bus;
    t_irq;
    t_port;
    t_units;
    t_restart;
    t_area;
    end_sim;
  end
endmodule
